//--- opmode_defines.svh
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH

// register indices, byte address is four times the index
`define PWR_CTRL_IDX 10'h087
`define PORT1_WAKE_IDX 10'h091
`define WAKE_CFG_IDX 10'h0C0
`define MODE_STAT_IDX 10'h0C1

// power control register fields
`define PWR_IDLE_BIT 0
`define PWR_STOP_BIT 1
`define PWR_FLAG_BIT 2
`define PWR_ADDRHI_BIT 3
`define PWR_ADDRHI_RESET 1'b1

// port 1 wake enable reset value
`define PORT1_WAKE_RESET 8'h00

// configuration register fields
`define CFG_EXTOSC_BIT 0
`define CFG_WDT_ON_BIT 1

// status register fields
`define STAT_MODE_LSB 0
`define STAT_SETTLE_BIT 2

// settling wait after stop, in high clocks and slow rc clocks
`define XTAL_WAIT_HCLK 12'd2048
`define RC_WAIT_HCLK 12'd64
`define SLOW_WAIT_CLK 12'd5

`endif

//--- opmode_pkg.sv
package opmode_pkg;

    // operating modes of the sequencer
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_STOP,
        MODE_SETTLE
    } mode_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer of the slave
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // oscillator and activity gates
    typedef struct packed {
        logic cpuRun;
        logic fastRcEn;
        logic extOscEn;
        logic slowRcEn;
        logic periphEn;
        logic intLogicEn;
    } clk_gate_t;

    // pin change detector state
    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] last;
        logic [15:0] changed;
    } pin_state_t;

    // settle timer state
    typedef struct packed {
        logic [1:0] slowSync;
        logic slowLast;
        logic busy;
        logic fastPhase;
        logic [11:0] count;
        logic done;
    } settle_state_t;

    // sequencer state
    typedef struct packed {
        mode_t mode;
        logic stopReq;
        logic idleReq;
        logic addrHi;
        logic genFlag;
        logic [7:0] port1WakeEn;
        logic useExternal;
        logic wdtAlwaysOn;
        apb_rsp_t rsp;
        clk_gate_t gates;
        logic wakeIrq;
        logic settleStart;
    } ctrl_state_t;

endpackage

//--- pin_wake_detect.sv
`timescale 1ns/10ps
`default_nettype none

module pin_wake_detect
    import opmode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] pins,
    output logic [15:0] changed
);

    pin_state_t st;
    pin_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // per pin: two flop sync, then any level change is a wake
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pin
            assign next_st.sync1[i] = pins[i];
            assign next_st.sync2[i] = st.sync1[i];
            assign next_st.last[i] = st.sync2[i];
            assign next_st.changed[i] = st.sync2[i] ^ st.last[i];
        end
    endgenerate

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign changed = st.changed;

endmodule

`default_nettype wire

//--- settle_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "opmode_defines.svh"

module settle_timer
    import opmode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic useExternal,
    input wire logic slowRcClk,
    output logic busy,
    output logic done
);

    settle_state_t st;
    settle_state_t next_st;
    logic slowEdge;

    ////////////////////////////////////////////////////////////////////////
    // high clock count first, then slow rc edges
    always_comb begin
        next_st = st;
        next_st.slowSync = {st.slowSync[0], slowRcClk};
        next_st.slowLast = st.slowSync[1];
        slowEdge = st.slowSync[1] & ~st.slowLast;
        next_st.done = 1'b0;
        if (start) begin
            next_st.busy = 1'b1;
            next_st.fastPhase = 1'b1;
            next_st.count = useExternal ? `XTAL_WAIT_HCLK - 12'd1
                                        : `RC_WAIT_HCLK - 12'd1;
        end else if (st.busy && st.fastPhase) begin
            if (st.count == 12'd0) begin
                next_st.fastPhase = 1'b0;
                next_st.count = `SLOW_WAIT_CLK - 12'd1;
            end else begin
                next_st.count = st.count - 12'd1;
            end
        end else if (st.busy && slowEdge) begin
            if (st.count == 12'd0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count - 12'd1;
            end
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;
    assign done = st.done;

endmodule

`default_nettype wire

//--- operating_mode_wake_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "opmode_defines.svh"

// Functional notes
// - reset always lands in normal running mode
// - stop bit set enters stop mode
// - hardware clears stop bit on wake
// - idle bit set enters idle, clock runs
// - hardware clears idle bit, back to normal
// - stop halts all oscillators, slow rc if watchdog
// - stop keeps all state and memory
// - stop holds peripherals and interrupts inactive
// - idle keeps system clock peripherals running
// - idle wakes on pins or enabled interrupt
// - stop wakes only on pins or reset
// - pin wake event raises its interrupt request
// - crystal wake waits 2048 plus 5 slow
// - fast rc wake waits 64 plus 5 slow
// - any rising or falling pin change wakes
// - port0 always wakes, port1 per enable bit
// - port1 wake enable, eight bits, reset zero
// - stop bit is bit 1, reset zero
// - idle bit is bit 0, reset zero
module operating_mode_wake_ctrl
    import opmode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire apb_req_t apbReq,
    output var apb_rsp_t apbRsp,
    input wire logic [7:0] port0Pins,
    input wire logic [7:0] port1Pins,
    input wire logic slowRcClk,
    input wire logic intPending,
    input wire logic globalIntEnable,
    output var clk_gate_t clkGates,
    output var mode_t opMode,
    output var logic wakeIrq
);

    ctrl_state_t st;
    ctrl_state_t next_st;
    logic [15:0] pinChanged;
    logic settleBusy;
    logic settleDone;
    logic portWake;
    logic intWake;
    logic access;
    logic hit;
    logic writeNow;
    logic [9:0] regIdx;
    logic [31:0] readData;

    ////////////////////////////////////////////////////////////////////////
    // pin change detection on both ports
    pin_wake_detect u_pins (
        .clk(clk),
        .rst(rst),
        .pins({port1Pins, port0Pins}),
        .changed(pinChanged)
    );

    // oscillator settling wait after stop
    settle_timer u_settle (
        .clk(clk),
        .rst(rst),
        .start(st.settleStart),
        .useExternal(st.useExternal),
        .slowRcClk(slowRcClk),
        .busy(settleBusy),
        .done(settleDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // wake sources
    always_comb begin
        portWake = (|pinChanged[7:0]) | (|(pinChanged[15:8] & st.port1WakeEn));
        intWake = intPending & globalIntEnable;
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    always_comb begin
        access = apbReq.psel & apbReq.penable;
        regIdx = apbReq.paddr[11:2];
        hit = (regIdx == `PWR_CTRL_IDX) || (regIdx == `PORT1_WAKE_IDX) ||
              (regIdx == `WAKE_CFG_IDX) || (regIdx == `MODE_STAT_IDX);
        writeNow = access & st.rsp.pready & apbReq.pwrite & ~st.rsp.pslverr;
    end

    // read data mux, unused bits read zero
    always_comb begin
        readData = 32'h0000_0000;
        case (regIdx)
            `PWR_CTRL_IDX: begin
                readData[`PWR_IDLE_BIT] = st.idleReq;
                readData[`PWR_STOP_BIT] = st.stopReq;
                readData[`PWR_FLAG_BIT] = st.genFlag;
                readData[`PWR_ADDRHI_BIT] = st.addrHi;
            end
            `PORT1_WAKE_IDX: begin
                readData[7:0] = st.port1WakeEn;
            end
            `WAKE_CFG_IDX: begin
                readData[`CFG_EXTOSC_BIT] = st.useExternal;
                readData[`CFG_WDT_ON_BIT] = st.wdtAlwaysOn;
            end
            `MODE_STAT_IDX: begin
                readData[`STAT_MODE_LSB +: 2] = st.mode;
                readData[`STAT_SETTLE_BIT] = settleBusy;
            end
            default: begin
                readData = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: bus answer, mode machine, register writes, gates
    always_comb begin
        next_st = st;
        next_st.wakeIrq = 1'b0;
        next_st.settleStart = 1'b0;

        // one wait state, then pready with data
        if (access && !st.rsp.pready) begin
            next_st.rsp.pready = 1'b1;
            next_st.rsp.pslverr = ~hit;
            next_st.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : readData;
        end else begin
            next_st.rsp.pready = 1'b0;
            next_st.rsp.pslverr = 1'b0;
        end

        // mode machine, state in st is kept untouched in low power
        case (st.mode)
            MODE_RUN: begin
                if (st.stopReq) begin
                    next_st.mode = MODE_STOP;
                end else if (st.idleReq) begin
                    next_st.mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (portWake || intWake) begin
                    next_st.mode = MODE_RUN;
                    next_st.idleReq = 1'b0;
                    next_st.wakeIrq = portWake;
                end
            end
            MODE_STOP: begin
                if (portWake) begin
                    next_st.mode = MODE_SETTLE;
                    next_st.stopReq = 1'b0;
                    next_st.idleReq = 1'b0;
                    next_st.settleStart = 1'b1;
                    next_st.wakeIrq = 1'b1;
                end
            end
            MODE_SETTLE: begin
                if (settleDone) begin
                    next_st.mode = MODE_RUN;
                end
            end
            default: begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // software writes land after hardware clears, so a set wins
        if (writeNow) begin
            case (regIdx)
                `PWR_CTRL_IDX: begin
                    next_st.idleReq = apbReq.pwdata[`PWR_IDLE_BIT];
                    next_st.stopReq = apbReq.pwdata[`PWR_STOP_BIT];
                    next_st.genFlag = apbReq.pwdata[`PWR_FLAG_BIT];
                    next_st.addrHi = apbReq.pwdata[`PWR_ADDRHI_BIT];
                end
                `PORT1_WAKE_IDX: begin
                    next_st.port1WakeEn = apbReq.pwdata[7:0];
                end
                `WAKE_CFG_IDX: begin
                    next_st.useExternal = apbReq.pwdata[`CFG_EXTOSC_BIT];
                    next_st.wdtAlwaysOn = apbReq.pwdata[`CFG_WDT_ON_BIT];
                end
                default: begin
                    next_st.port1WakeEn = st.port1WakeEn;
                end
            endcase
        end

        // oscillator and activity gates per next mode
        case (next_st.mode)
            MODE_RUN: begin
                next_st.gates.cpuRun = 1'b1;
                next_st.gates.fastRcEn = ~next_st.useExternal;
                next_st.gates.extOscEn = next_st.useExternal;
                next_st.gates.slowRcEn = 1'b1;
                next_st.gates.periphEn = 1'b1;
                next_st.gates.intLogicEn = 1'b1;
            end
            MODE_IDLE: begin
                next_st.gates.cpuRun = 1'b0;
                next_st.gates.fastRcEn = ~next_st.useExternal;
                next_st.gates.extOscEn = next_st.useExternal;
                next_st.gates.slowRcEn = 1'b1;
                next_st.gates.periphEn = 1'b1;
                next_st.gates.intLogicEn = 1'b1;
            end
            MODE_STOP: begin
                next_st.gates.cpuRun = 1'b0;
                next_st.gates.fastRcEn = 1'b0;
                next_st.gates.extOscEn = 1'b0;
                next_st.gates.slowRcEn = next_st.wdtAlwaysOn;
                next_st.gates.periphEn = 1'b0;
                next_st.gates.intLogicEn = 1'b0;
            end
            MODE_SETTLE: begin
                next_st.gates.cpuRun = 1'b0;
                next_st.gates.fastRcEn = ~next_st.useExternal;
                next_st.gates.extOscEn = next_st.useExternal;
                next_st.gates.slowRcEn = 1'b1;
                next_st.gates.periphEn = 1'b0;
                next_st.gates.intLogicEn = 1'b0;
            end
            default: begin
                next_st.gates = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register the state; stop and idle leave it untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.mode <= MODE_RUN;
            st.addrHi <= `PWR_ADDRHI_RESET;
            st.port1WakeEn <= `PORT1_WAKE_RESET;
            st.gates.cpuRun <= 1'b1;
            st.gates.fastRcEn <= 1'b1;
            st.gates.slowRcEn <= 1'b1;
            st.gates.periphEn <= 1'b1;
            st.gates.intLogicEn <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign apbRsp = st.rsp;
    assign clkGates = st.gates;
    assign opMode = st.mode;
    assign wakeIrq = st.wakeIrq;

endmodule

`default_nettype wire

//--- opmode_wake_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "opmode_defines.svh"

module opmode_wake_checker
    import opmode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    input wire logic [7:0] port0Pins,
    input wire logic [7:0] port1Pins,
    input wire logic slowRcClk,
    input wire logic intPending,
    input wire logic globalIntEnable,
    input wire clk_gate_t clkGates,
    input wire mode_t opMode,
    input wire logic wakeIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic pwrWr;
    logic [12:0] settleCnt;
    // accepted write to power control
    assign pwrWr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready
        && apbReq.paddr[11:2] == `PWR_CTRL_IDX;
    // cycles spent settling
    always_ff @(posedge clk) begin
        if (rst || opMode != MODE_SETTLE) begin
            settleCnt <= '0;
        end else if (settleCnt != 13'h1FFF) begin
            settleCnt <= settleCnt + 13'h0001;
        end
    end
    ////////////////////////////////////////
    reset_run_a: assert property (disable iff (1'b0)
        rst |=> opMode == MODE_RUN && clkGates.cpuRun) else $error("no run after reset");
    stop_entry_a: assert property (
        pwrWr && apbReq.pwdata[1] && opMode == MODE_RUN |-> ##[1:2] opMode == MODE_STOP)
        else $error("stop not entered");
    idle_entry_a: assert property (
        pwrWr && apbReq.pwdata[1:0] == 2'b01 && opMode == MODE_RUN
        |-> ##[1:2] opMode == MODE_IDLE) else $error("idle not entered");
    stop_gates_a: assert property (opMode == MODE_STOP |-> clkGates.cpuRun == 1'b0
        && !clkGates.fastRcEn && !clkGates.extOscEn && !clkGates.periphEn
        && !clkGates.intLogicEn) else $error("gates open in stop");
    idle_gates_a: assert property (opMode == MODE_IDLE |-> !clkGates.cpuRun
        && clkGates.periphEn && clkGates.intLogicEn) else $error("idle gates wrong");
    idle_wake_a: assert property (
        opMode == MODE_IDLE && intPending && globalIntEnable |=> opMode == MODE_RUN)
        else $error("idle interrupt wake missed");
    stop_hold_a: assert property (opMode == MODE_STOP
        |=> opMode == MODE_STOP || opMode == MODE_SETTLE) else $error("bad stop exit");
    stop_exit_a: assert property (opMode == MODE_STOP ##1 opMode != MODE_STOP
        |-> opMode == MODE_SETTLE && wakeIrq) else $error("stop exit without irq");
    wake_irq_a: assert property (wakeIrq |-> ($past(opMode) == MODE_IDLE
        || $past(opMode) == MODE_STOP) ##1 !wakeIrq) else $error("stray wake irq");
    settle_min_a: assert property (
        opMode == MODE_SETTLE && settleCnt < 13'd64 |=> opMode == MODE_SETTLE)
        else $error("settle too short");
endmodule

bind operating_mode_wake_ctrl opmode_wake_checker chk (.clk(clk), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .port0Pins(port0Pins), .port1Pins(port1Pins),
    .slowRcClk(slowRcClk), .intPending(intPending), .globalIntEnable(globalIntEnable),
    .clkGates(clkGates), .opMode(opMode), .wakeIrq(wakeIrq));
`default_nettype wire

//--- wake_partner.sv
`timescale 1ns/10ps
`default_nettype none

module wake_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] flip,
    output logic [7:0] port0Pins,
    output logic [7:0] port1Pins,
    output logic slowRcClk
);
    logic [15:0] level;
    // pin levels toggle on request
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= '0;
        end else begin
            level <= level ^ flip;
        end
    end
    assign port0Pins = level[7:0];
    assign port1Pins = level[15:8];
    // free running slow rc, phase unrelated
    initial begin
        slowRcClk = 1'b0;
        #3;
        forever #100 slowRcClk = ~slowRcClk;
    end
endmodule
`default_nettype wire

//--- operating_mode_wake_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module operating_mode_wake_ctrl_tb
    import opmode_pkg::*;
;
    localparam logic [11:0] pwrAddr = 12'h21C;
    localparam logic [11:0] p1wAddr = 12'h244;
    localparam logic [11:0] cfgAddr = 12'h300;
    localparam logic [11:0] badAddr = 12'h3F0;
    logic clk, rst, intPending, globalIntEnable, slowRcClk, wakeIrq, err;
    logic [7:0] port0Pins, port1Pins;
    logic [15:0] flip;
    logic [31:0] rdata;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    clk_gate_t clkGates;
    mode_t opMode;
    int bad_count = 0;
    int checks = 0;
    int irqCount = 0;

    operating_mode_wake_ctrl dut (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .port0Pins(port0Pins), .port1Pins(port1Pins), .slowRcClk(slowRcClk),
        .intPending(intPending), .globalIntEnable(globalIntEnable),
        .clkGates(clkGates), .opMode(opMode), .wakeIrq(wakeIrq));
    wake_partner far (.clk(clk), .rst(rst), .flip(flip), .port0Pins(port0Pins),
        .port1Pins(port1Pins), .slowRcClk(slowRcClk));

    // clock and wake pulse tally
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wakeIrq === 1'b1) irqCount <= irqCount + 1;
    end
    ////////////////////////////////////////
    task give_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= w;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        chk("pready", 1, n < 50);
        rdata = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, '0);
        chk("prdata", exp, rdata);
        chk("pslverr", {31'h0, e}, {31'h0, err});
    endtask
    task wait_mode(input mode_t m);
        int n;
        n = 0;
        while (opMode !== m && n < 5000) begin
            @(posedge clk);
            n++;
        end
        chk("opMode", m, opMode);
    endtask
    task pins(input logic [15:0] m);
        flip <= m;
        @(posedge clk);
        flip <= '0;
    endtask
    ////////////////////////////////////////
    task t_reset;
        chk("opMode", MODE_RUN, opMode);
        chk("gates", 32'h37, clkGates);
        rdchk(pwrAddr, 32'h08, 1'b0);
        rdchk(p1wAddr, 32'h00, 1'b0);
    endtask
    task t_regs;
        apb(1'b1, p1wAddr, 32'hFFFFFFA5);
        rdchk(p1wAddr, 32'hA5, 1'b0);
        apb(1'b1, badAddr, 32'h0B);
        rdchk(badAddr, 32'h00, 1'b1);
        rdchk(pwrAddr, 32'h08, 1'b0);
    endtask
    task t_idle;
        int n0;
        n0 = irqCount;
        apb(1'b1, pwrAddr, 32'h09);
        wait_mode(MODE_IDLE);
        chk("gates", 32'h17, clkGates);
        intPending <= 1'b1;
        repeat (6) @(posedge clk);
        chk("opMode", MODE_IDLE, opMode);
        globalIntEnable <= 1'b1;
        wait_mode(MODE_RUN);
        intPending <= 1'b0;
        globalIntEnable <= 1'b0;
        rdchk(pwrAddr, 32'h08, 1'b0);
        apb(1'b1, pwrAddr, 32'h09);
        wait_mode(MODE_IDLE);
        pins(16'h0008);
        wait_mode(MODE_RUN);
        repeat (2) @(posedge clk);
        chk("wake irqs", n0 + 1, irqCount);
    endtask
    task t_stop_rc;
        int n0;
        n0 = irqCount;
        apb(1'b1, p1wAddr, 32'h02);
        apb(1'b1, pwrAddr, 32'h0B);
        wait_mode(MODE_STOP);
        chk("gates", 32'h00, clkGates);
        intPending <= 1'b1;
        globalIntEnable <= 1'b1;
        repeat (8) @(posedge clk);
        pins(16'h0100);
        repeat (8) @(posedge clk);
        chk("opMode", MODE_STOP, opMode);
        intPending <= 1'b0;
        globalIntEnable <= 1'b0;
        pins(16'h0200);
        wait_mode(MODE_SETTLE);
        wait_mode(MODE_RUN);
        chk("wake irqs", n0 + 1, irqCount);
        rdchk(pwrAddr, 32'h08, 1'b0);
        rdchk(p1wAddr, 32'h02, 1'b0);
    endtask
    task t_stop_xt;
        int n;
        apb(1'b1, cfgAddr, 32'h03);
        apb(1'b1, pwrAddr, 32'h0A);
        wait_mode(MODE_STOP);
        chk("gates", 32'h04, clkGates);
        pins(16'h0008);
        wait_mode(MODE_SETTLE);
        rdchk(12'h304, 32'h07, 1'b0);
        n = 0;
        while (opMode === MODE_SETTLE && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("settle long", 1, n >= 2048);
        chk("opMode", MODE_RUN, opMode);
    endtask
    ////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        rst = 1'b1;
        apbReq = '0;
        intPending = 1'b0;
        globalIntEnable = 1'b0;
        flip = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_idle;
        t_stop_rc;
        t_stop_xt;
        give_verdict;
    end
    initial begin
        #400000;
        bad_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
